// *** design/mssq_fifo.sv ***
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mssq_fifo #(
    parameter int unsigned WIDTH = 24,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    // Pointer and count update
    always_comb begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = (AW+1)'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage write
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
endmodule : mssq_fifo

// *** design/mssq_pkg.sv ***
// Package of constants and types for the scan sequencer
// Functional notes
// - Digital port and counter capture takes no conversion slot.
// - Digital and counter ride along only when list has an analog entry.
// - No digital sampling in idle remainder of a scan period.
// - Scan list of 512 entries, any channel order, repeats allowed.
// - Entries converted in list order, 1 us each by default.
// - Settling selectable 1 us, 5 us, 10 us or 1 ms for all entries.
// - Single analog entry sustains full 1 MHz with digital capture.
// - Each entry carries its own gain code, one of seven ranges.
// - One 16-bit converter muxed over 16 channels from current entry.
// - Input scanning independent of analog and pattern outputs.
// - Scan period programmable up to 1 s.
// - 32-bit counter sent as low word then high word.
package mssq_pkg;
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned SETTLE_1US_NS = 1_000;
    localparam int unsigned SETTLE_5US_NS = 5_000;
    localparam int unsigned SETTLE_10US_NS = 10_000;
    localparam int unsigned SETTLE_1MS_NS = 1_000_000;
    localparam int unsigned PERIOD_MAX_S  = 1;
    // Cycle counts derived from the clock rate
    localparam logic [31:0] CYC_1US   = 32'(SETTLE_1US_NS * (CLK_HZ / 1_000_000) / 1_000);
    localparam logic [31:0] CYC_5US   = 32'(SETTLE_5US_NS * (CLK_HZ / 1_000_000) / 1_000);
    localparam logic [31:0] CYC_10US  = 32'(SETTLE_10US_NS * (CLK_HZ / 1_000_000) / 1_000);
    localparam logic [31:0] CYC_1MS   = 32'(SETTLE_1MS_NS / 1_000 * (CLK_HZ / 1_000_000));
    localparam logic [31:0] CYC_PERIOD_MAX = 32'(PERIOD_MAX_S * CLK_HZ);
    // First entry of a scan: tick, start, answer and return cycles outside the count
    localparam logic [31:0] SETTLE_LEAD = 32'h4;
    // Later entries: start, answer and reload cycles outside the count
    localparam logic [31:0] SETTLE_STEP = 32'h3;
    localparam int unsigned LIST_DEPTH = 512;
    localparam int unsigned LIST_AW    = 9;
    localparam int unsigned NUM_CH     = 16;
    localparam int unsigned NUM_CTR    = 4;
    localparam int unsigned SAMPLE_W   = 16;
    localparam logic [2:0]  GAIN_MAX   = 3'h6;

    // Settling selection codes
    typedef enum logic [1:0] {
        MSSQ_SET_1US  = 2'h0,
        MSSQ_SET_5US  = 2'h1,
        MSSQ_SET_10US = 2'h2,
        MSSQ_SET_1MS  = 2'h3
    } mssq_settle_t;

    // Sample source tags
    typedef enum logic [2:0] {
        MSSQ_SRC_ANALOG = 3'h0,
        MSSQ_SRC_DIGIN  = 3'h1,
        MSSQ_SRC_CTR_LO = 3'h2,
        MSSQ_SRC_CTR_HI = 3'h3
    } mssq_src_t;

    // Scan list entry
    typedef struct packed {
        logic [3:0] chan;
        logic [2:0] gain;
    } mssq_entry_t;

    // Streamed sample word
    typedef struct packed {
        mssq_src_t             src;
        logic [1:0]            idx;
        logic [SAMPLE_W-1:0]   data;
    } mssq_sample_t;

    localparam int unsigned SAMPLE_BITS = $bits(mssq_sample_t);
endpackage : mssq_pkg

// *** design/mssq_top.sv ***
// Scan sequencer: scan list walk, settling, pacing and sample stream
`timescale 1ns/1ps
module mssq_top
    import mssq_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = 32,
    parameter logic [31:0] SETTLE_1MS_CYC = CYC_1MS,
    parameter logic [31:0] PERIOD_MAX_CYC = CYC_PERIOD_MAX
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    // Scan list write port
    input  wire logic                   list_wr,
    input  wire logic [LIST_AW-1:0]     list_addr,
    input  wire mssq_entry_t            list_data,
    // Configuration
    input  wire logic [LIST_AW-1:0]     list_last,
    input  wire mssq_settle_t           settle_sel,
    input  wire logic [31:0]            scan_period,
    input  wire logic                   ext_pace,
    input  wire logic                   dig_en,
    input  wire logic                   dig_every,
    input  wire logic [NUM_CTR-1:0]     ctr_en,
    input  wire logic [NUM_CTR-1:0]     ctr_wide,
    input  wire logic                   scan_enable,
    input  wire logic                   trig_in,
    input  wire logic                   ext_scan_clk,
    // Digital and counter inputs
    input  wire logic [SAMPLE_W-1:0]    dig_port,
    input  wire logic [NUM_CTR*32-1:0]  ctr_value,
    // Converter
    output logic [3:0]                  adc_chan,
    output logic [2:0]                  adc_gain,
    output logic                        adc_start,
    input  wire logic                   adc_done,
    input  wire logic [SAMPLE_W-1:0]    adc_data,
    // Sample stream
    output logic                        smp_valid,
    input  wire logic                   smp_ready,
    output mssq_sample_t                smp_data,
    // Status
    output logic                        busy,
    output logic                        overrun,
    output logic                        stalled
);
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_WAIT   = 5'b00010,
        ST_SIDE   = 5'b00100,
        ST_SETTLE = 5'b01000,
        ST_CONV   = 5'b10000
    } mssq_state_t;

    mssq_entry_t      list_reg [LIST_DEPTH];
    mssq_state_t      st_reg, st_next;
    logic [LIST_AW-1:0] idx_reg, idx_next;
    logic [31:0]      set_reg, set_next, per_reg, per_next;
    logic [3:0]       side_reg, side_next;
    logic             ovr_reg, ovr_next, armed_reg, armed_next;
    logic [2:0]       trg_sync, clk_sync;
    logic             trig_rise, tick_ext, tick, fin_ok;
    logic             f_valid, f_ready;
    mssq_sample_t     f_data;
    logic [3:0]       adc_chan_reg;
    logic [2:0]       adc_gain_reg;
    logic             adc_start_reg, adc_start_next;

    // Settling count for a selection code
    function automatic logic [31:0] settle_cycles(input mssq_settle_t s);
        unique case (s)
            MSSQ_SET_1US:  settle_cycles = CYC_1US;
            MSSQ_SET_5US:  settle_cycles = CYC_5US;
            MSSQ_SET_10US: settle_cycles = CYC_10US;
            MSSQ_SET_1MS:  settle_cycles = SETTLE_1MS_CYC;
        endcase
    endfunction : settle_cycles

    // Scan list storage, free order and repeats
    always_ff @(posedge sys_clk) begin
        if (list_wr) begin
            list_reg[list_addr] <= list_data;
        end
    end

    // Pin synchronisers with edge history
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            trg_sync <= '0;
            clk_sync <= '0;
        end else begin
            trg_sync <= {trg_sync[1:0], trig_in};
            clk_sync <= {clk_sync[1:0], ext_scan_clk};
        end
    end

    assign trig_rise = trg_sync[1] && !trg_sync[2];
    assign tick_ext  = clk_sync[1] && !clk_sync[2];
    // Scan tick from external clock or internal period counter
    assign tick      = ext_pace ? tick_ext : (per_reg == '0);
    assign fin_ok    = f_ready;

    // Side-sample selection: slot 8 digital, slots 0 to 7 counter words
    function automatic mssq_sample_t side_word(input logic [3:0] s);
        mssq_sample_t w;
        logic [1:0]   c;
        w = '0;
        c = s[2:1];
        if (s == 4'h8) begin
            w.src  = MSSQ_SRC_DIGIN;
            w.data = dig_port;
        end else if (!s[0]) begin
            w.src  = MSSQ_SRC_CTR_LO;
            w.idx  = c;
            w.data = ctr_value[c*32 +: SAMPLE_W];
        end else begin
            w.src  = MSSQ_SRC_CTR_HI;
            w.idx  = c;
            w.data = ctr_value[c*32+SAMPLE_W +: SAMPLE_W];
        end
        return w;
    endfunction : side_word

    // Whether a side slot is wanted
    function automatic logic side_wanted(input logic [3:0] s);
        if (s == 4'h8) begin
            return dig_en;
        end
        if (s[3]) begin
            return 1'b0;
        end
        return ctr_en[s[2:1]] && (!s[0] || ctr_wide[s[2:1]]);
    endfunction : side_wanted

    // Sequencer next state
    always_comb begin
        st_next        = st_reg;
        idx_next       = idx_reg;
        set_next       = set_reg;
        per_next       = per_reg;
        side_next      = side_reg;
        ovr_next       = ovr_reg;
        armed_next     = armed_reg;
        adc_start_next = 1'b0;
        f_valid        = 1'b0;
        f_data         = '0;
        // Free-running internal period counter, up to 1 s
        if (armed_reg && !ext_pace) begin
            if (per_reg == '0) begin
                per_next = (scan_period > PERIOD_MAX_CYC) ? PERIOD_MAX_CYC - 1 :
                           ((scan_period == '0) ? '0 : scan_period - 1);
            end else begin
                per_next = per_reg - 1;
            end
        end
        // Tick during an unfinished scan flags overrun while scan_enable is high
        if (armed_reg && tick && (st_reg != ST_WAIT) && (st_reg != ST_IDLE)) begin
            ovr_next = 1'b1;
        end
        unique case (st_reg)
            ST_IDLE: begin
                if (scan_enable && trig_rise) begin
                    armed_next = 1'b1;
                    per_next   = '0;
                    st_next    = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Idle remainder of the period: nothing sampled
                if (!scan_enable) begin
                    armed_next = 1'b0;
                    st_next    = ST_IDLE;
                end else if (tick) begin
                    idx_next  = '0;
                    side_next = 4'h8;
                    set_next  = settle_cycles(settle_sel) - SETTLE_LEAD;
                    st_next   = ST_SIDE;
                end
            end
            ST_SIDE: begin
                // Side captures go out while the current entry settles
                if (set_reg != '0) begin
                    set_next = set_reg - 1;
                end
                if (side_wanted(side_reg)) begin
                    f_valid = 1'b1;
                    f_data  = side_word(side_reg);
                end
                if (!side_wanted(side_reg) || fin_ok) begin
                    if (side_reg == 4'h8) begin
                        // Counters only at scan start
                        side_next = (idx_reg == '0) ? 4'h0 : 4'hF;
                    end else if (side_reg == 4'h7) begin
                        side_next = 4'hF;
                    end else begin
                        side_next = side_reg + 4'h1;
                    end
                end
                if ((side_reg == 4'hF) || (side_reg == 4'h7 && (!side_wanted(side_reg) || fin_ok))) begin
                    st_next  = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (set_reg == '0) begin
                    adc_start_next = 1'b1;
                    st_next        = ST_CONV;
                end else begin
                    set_next = set_reg - 1;
                end
            end
            ST_CONV: begin
                if (adc_done && fin_ok) begin
                    f_valid = 1'b1;
                    f_data  = '{src: MSSQ_SRC_ANALOG, idx: 2'h0, data: adc_data};
                    if (idx_reg == list_last) begin
                        st_next = ST_WAIT;
                    end else begin
                        // Next entry in list order
                        idx_next  = idx_reg + 1'b1;
                        side_next = dig_every ? 4'h8 : 4'hF;
                        st_next   = dig_every ? ST_SIDE : ST_SETTLE;
                        set_next  = settle_cycles(settle_sel) - SETTLE_STEP;
                    end
                end
            end
            default: st_next = ST_IDLE;
        endcase
        if (!scan_enable && st_reg != ST_IDLE && st_reg != ST_WAIT) begin
            ovr_next = ovr_reg;
        end
    end

    // Sequencer registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_reg        <= ST_IDLE;
            idx_reg       <= '0;
            set_reg       <= '0;
            per_reg       <= '0;
            side_reg      <= '0;
            ovr_reg       <= 1'b0;
            armed_reg     <= 1'b0;
            adc_start_reg <= 1'b0;
            adc_chan_reg  <= '0;
            adc_gain_reg  <= '0;
        end else begin
            st_reg        <= st_next;
            idx_reg       <= idx_next;
            set_reg       <= set_next;
            per_reg       <= per_next;
            side_reg      <= side_next;
            ovr_reg       <= ovr_next;
            armed_reg     <= armed_next;
            adc_start_reg <= adc_start_next;
            adc_chan_reg  <= list_reg[idx_next].chan;
            adc_gain_reg  <= list_reg[idx_next].gain;
        end
    end

    // Output FIFO between sequencer and host stream
    mssq_fifo #(
        .WIDTH (SAMPLE_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .in_data   (f_data),
        .out_valid (smp_valid),
        .out_ready (smp_ready),
        .out_data  (smp_data)
    );

    // Outputs; scanning touches no output path logic
    assign adc_chan  = adc_chan_reg;
    assign adc_gain  = adc_gain_reg;
    assign adc_start = adc_start_reg;
    assign busy      = armed_reg;
    assign overrun   = ovr_reg;
    assign stalled   = !f_ready;
endmodule : mssq_top

// *** verif/mssq_chk.sv ***
// Port checker for the scan sequencer
`timescale 1ns/1ps
module mssq_chk
    import mssq_pkg::*;
(
    // Clock and reset
    input wire logic         sys_clk,
    input wire logic         srst,
    // Converter
    input wire logic [3:0]   adc_chan,
    input wire logic [2:0]   adc_gain,
    input wire logic         adc_start,
    // Stream and status
    input wire logic         smp_valid,
    input wire logic         smp_ready,
    input wire mssq_sample_t smp_data,
    input wire logic         busy,
    input wire logic         overrun,
    input wire logic         stalled
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Pacing overrun
    ovr_sticky_a: assert property (overrun |=> overrun)
        else $error("overrun cleared");
    ovr_cause_a: assert property ($rose(overrun) |-> $past(busy))
        else $error("overrun while idle");
    // Conversion start and entry fields
    start_gap_a: assert property (adc_start |=> !adc_start [*8])
        else $error("starts too close");
    entry_hold_a: assert property (adc_start |=> $stable(adc_chan) && $stable(adc_gain))
        else $error("entry moved in conversion");
    gain_range_a: assert property (adc_start |-> adc_gain <= GAIN_MAX)
        else $error("gain out of range");
    start_armed_a: assert property (adc_start |-> busy)
        else $error("start while idle");
    // Stream handshake
    stream_hold_a: assert property (smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
        else $error("sample dropped");
    full_valid_a: assert property (stalled |-> smp_valid)
        else $error("full with no data");
    // Main scenarios
    cover property (adc_start);
    cover property ($rose(overrun));
    cover property (stalled);
    cover property (smp_valid && smp_ready && smp_data.src == MSSQ_SRC_CTR_HI);
endmodule : mssq_chk

// *** verif/mssq_host.sv ***
// Host model draining the sample stream
`timescale 1ns/1ps
module mssq_host
    import mssq_pkg::*;
(
    // Clock and reset
    input wire logic         sys_clk,
    input wire logic         srst,
    // Stream from the device
    input wire logic         smp_valid,
    output logic             smp_ready,
    input wire mssq_sample_t smp_data,
    // Stall request from the bench
    input wire logic         hold
);
    mssq_sample_t q[$];
    logic         slow_reg = 1'b0;
    // Slow host: takes a word every other cycle, none while held
    always @(posedge sys_clk) begin
        slow_reg <= srst ? 1'b0 : !slow_reg;
        if (!srst && smp_valid && smp_ready) begin
            q.push_back(smp_data);
        end
    end
    assign smp_ready = !hold && !slow_reg;
endmodule : mssq_host

// *** verif/tb_top.sv ***
// Testbench for the scan sequencer
`timescale 1ns/1ps
module tb_top;
    import mssq_pkg::*;
    logic               sys_clk = 1'b0;
    logic               srst = 1'b1;
    logic               list_wr = 1'b0;
    logic [LIST_AW-1:0] list_addr = '0;
    mssq_entry_t        list_data = '0;
    logic [LIST_AW-1:0] list_last = '0;
    mssq_settle_t       settle_sel = MSSQ_SET_1US;
    logic [31:0]        scan_period = 32'hBB8;
    logic               dig_en = 1'b0;
    logic               dig_every = 1'b0;
    logic               ext_pace = 1'b0;
    logic               ext_scan_clk = 1'b0;
    logic [3:0]         ctr_en = '0;
    logic [3:0]         ctr_wide = '0;
    logic               scan_enable = 1'b0;
    logic               trig_in = 1'b0;
    logic               adc_done = 1'b0;
    logic [15:0]        adc_data = '0;
    logic               hold = 1'b0;
    logic [3:0]         adc_chan;
    logic [2:0]         adc_gain;
    logic               adc_start;
    logic               smp_valid;
    logic               smp_ready;
    mssq_sample_t       smp_data;
    logic               busy;
    logic               overrun;
    logic               stalled;
    int                 err_count = 0;
    int                 n_checks = 0;
    int                 n_start = 0;
    int                 cyc = 0;

    mssq_top #(.FIFO_DEPTH(32), .SETTLE_1MS_CYC(32'd800), .PERIOD_MAX_CYC(32'd4000)) u_mssq_top (
        .sys_clk(sys_clk), .srst(srst), .list_wr(list_wr), .list_addr(list_addr),
        .list_data(list_data), .list_last(list_last), .settle_sel(settle_sel),
        .scan_period(scan_period), .ext_pace(ext_pace), .dig_en(dig_en), .dig_every(dig_every),
        .ctr_en(ctr_en), .ctr_wide(ctr_wide), .scan_enable(scan_enable), .trig_in(trig_in),
        .ext_scan_clk(ext_scan_clk), .dig_port(16'h5AC3),
        .ctr_value(128'h3D3C_3B3A_2D2C_2B2A_1D1C_1B1A_0D0C_0B0A),
        .adc_chan(adc_chan), .adc_gain(adc_gain), .adc_start(adc_start),
        .adc_done(adc_done), .adc_data(adc_data), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_data(smp_data), .busy(busy), .overrun(overrun),
        .stalled(stalled));
    mssq_host u_mssq_host (.sys_clk(sys_clk), .srst(srst), .smp_valid(smp_valid),
        .smp_ready(smp_ready), .smp_data(smp_data), .hold(hold));

    // Clock, timeout, start counter and fast converter held until taken
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        n_start <= n_start + int'(adc_start);
        if (adc_start) begin
            adc_done <= 1'b1;
            adc_data <= {adc_chan, 1'b0, adc_gain, 8'hA5};
        end else if (adc_done && !stalled) begin
            adc_done <= 1'b0;
            adc_data <= ~adc_data;
        end
        if (cyc == 40000) begin
            err_count++;
            summarize();
        end
    end

    // Result comparisons
    task automatic cmp_smp(input mssq_sample_t g, input mssq_sample_t e);
        n_checks++;
        if (g.src !== e.src || g.data !== e.data || (e.src != MSSQ_SRC_ANALOG && g.idx !== e.idx)) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_smp
    task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_val
    function automatic mssq_sample_t an(input logic [3:0] c, input logic [2:0] g);
        return {MSSQ_SRC_ANALOG, 2'h0, c, 1'b0, g, 8'hA5};
    endfunction : an

    // Stimulus helpers
    task automatic wcyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wcyc
    task automatic wr(input int a, input logic [3:0] c, input logic [2:0] g);
        @(posedge sys_clk);
        list_wr <= 1'b1;
        list_addr <= 9'(a);
        list_data <= '{chan: c, gain: g};
        @(posedge sys_clk);
        list_wr <= 1'b0;
    endtask : wr
    task automatic go();
        @(posedge sys_clk);
        scan_enable <= 1'b1;
        trig_in <= 1'b1;
        wcyc(3);
        trig_in <= 1'b0;
    endtask : go
    task automatic stop();
        int k;
        @(posedge sys_clk);
        scan_enable <= 1'b0;
        for (k = 0; busy !== 1'b0 && k < 9000; k++) begin
            @(negedge sys_clk);
        end
        wcyc(20);
        u_mssq_host.q.delete();
    endtask : stop
    task automatic wq(input int n);
        for (int k = 0; u_mssq_host.q.size() < n && k < 9000; k++) begin
            @(negedge sys_clk);
        end
        cmp_val(u_mssq_host.q.size(), n);
    endtask : wq
    task automatic wst(output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (adc_start !== 1'b1 && n < 3000);
    endtask : wst

    // Side words, list order, gains and idle remainder
    task automatic t_order();
        wr(0, 4'h5, 3'h6);
        wr(1, 4'h5, 3'h0);
        wr(2, 4'h2, 3'h3);
        list_last <= 9'h2;
        dig_en <= 1'b1;
        ctr_en <= 4'h3;
        ctr_wide <= 4'h2;
        go();
        wq(7);
        wcyc(500);
        cmp_val(u_mssq_host.q.size(), 7);
        cmp_smp(u_mssq_host.q[0], {MSSQ_SRC_DIGIN, 2'h0, 16'h5AC3});
        cmp_smp(u_mssq_host.q[1], {MSSQ_SRC_CTR_LO, 2'h0, 16'h0B0A});
        cmp_smp(u_mssq_host.q[2], {MSSQ_SRC_CTR_LO, 2'h1, 16'h1B1A});
        cmp_smp(u_mssq_host.q[3], {MSSQ_SRC_CTR_HI, 2'h1, 16'h1D1C});
        cmp_smp(u_mssq_host.q[4], an(4'h5, 3'h6));
        cmp_smp(u_mssq_host.q[5], an(4'h5, 3'h0));
        cmp_smp(u_mssq_host.q[6], an(4'h2, 3'h3));
        stop();
    endtask : t_order

    // Every settling code, measured between two starts
    task automatic t_settle();
        int gap;
        int lim [4] = '{40, 200, 400, 800};
        dig_en <= 1'b0;
        ctr_en <= 4'h0;
        list_last <= 9'h1;
        for (int s = 0; s < 4; s++) begin
            settle_sel <= mssq_settle_t'(s);
            go();
            wst(gap);
            wst(gap);
            cmp_val(gap >= lim[s] - 4 && gap <= lim[s] + 12, 1);
            stop();
        end
        settle_sel <= MSSQ_SET_1US;
    endtask : t_settle

    // One entry at the full rate with side words
    task automatic t_rate();
        int a;
        list_last <= 9'h0;
        dig_en <= 1'b1;
        ctr_en <= 4'h1;
        ctr_wide <= 4'h1;
        scan_period <= 32'h28;
        go();
        wcyc(20);
        a = n_start;
        wcyc(400);
        cmp_val(n_start - a, 10);
        cmp_val(overrun, 0);
        stop();
    endtask : t_rate

    // Period shorter than the scan, cleared only by reset
    task automatic t_over();
        for (int i = 3; i < 8; i++) begin
            wr(i, 4'(i), 3'h1);
        end
        list_last <= 9'h7;
        scan_period <= 32'h64;
        go();
        wcyc(400);
        cmp_val(overrun, 1);
        stop();
        cmp_val(overrun, 1);
        srst <= 1'b1;
        wcyc(3);
        srst <= 1'b0;
        wcyc(4);
        cmp_val(overrun, 0);
        scan_period <= 32'hBB8;
    endtask : t_over

    // Host stalls until the buffer refuses, then drains it
    task automatic t_stall();
        hold <= 1'b1;
        dig_en <= 1'b0;
        ctr_en <= 4'h0;
        for (int i = 0; i < 40; i++) begin
            wr(i, 4'(i), 3'(i % 7));
        end
        list_last <= 9'h27;
        go();
        for (int k = 0; stalled !== 1'b1 && k < 3000; k++) begin
            @(negedge sys_clk);
        end
        cmp_val(stalled, 1);
        cmp_val(u_mssq_host.q.size(), 0);
        hold <= 1'b0;
        wq(40);
        for (int i = 0; i < 40; i++) begin
            cmp_smp(u_mssq_host.q[i], an(4'(i), 3'(i % 7)));
        end
        wcyc(10);
        cmp_val(smp_valid, 0);
        stop();
    endtask : t_stall

    // Digital before every entry, paced by the external scan clock only
    task automatic t_every();
        list_last <= 9'h1;
        dig_en <= 1'b1;
        dig_every <= 1'b1;
        ext_pace <= 1'b1;
        scan_period <= 32'h28;
        go();
        ext_scan_clk <= 1'b1;
        wcyc(4);
        ext_scan_clk <= 1'b0;
        wq(4);
        wcyc(200);
        cmp_val(u_mssq_host.q.size(), 4);
        cmp_smp(u_mssq_host.q[0], {MSSQ_SRC_DIGIN, 2'h0, 16'h5AC3});
        cmp_smp(u_mssq_host.q[1], an(4'h0, 3'h0));
        cmp_smp(u_mssq_host.q[2], {MSSQ_SRC_DIGIN, 2'h0, 16'h5AC3});
        cmp_smp(u_mssq_host.q[3], an(4'h1, 3'h1));
        cmp_val(overrun, 0);
        stop();
        dig_every <= 1'b0;
        ext_pace <= 1'b0;
        scan_period <= 32'hBB8;
    endtask : t_every

    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // Main sequence
    initial begin
        wcyc(3);
        srst <= 1'b0;
        wcyc(4);
        cmp_val({busy, overrun, smp_valid, stalled, adc_start}, 0);
        t_order();
        t_settle();
        t_rate();
        t_over();
        t_stall();
        t_every();
        summarize();
    end
endmodule : tb_top

bind mssq_top mssq_chk u_mssq_chk (.sys_clk(sys_clk), .srst(srst), .adc_chan(adc_chan),
    .adc_gain(adc_gain), .adc_start(adc_start), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_data(smp_data), .busy(busy), .overrun(overrun),
    .stalled(stalled));
